// ---- pct_pkg.sv ----
// constants for the power condition timer descriptor block
// assumes a single 10 MHz clock and an AXI4-Lite register port
package pct_pkg;

  // clock and timer unit
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned TIMER_UNIT_MS  = 100;
  localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1000) * TIMER_UNIT_MS;

  // timer value that means "at least the saturated maximum"
  localparam logic [31:0] TIMER_SATURATED = 32'hFFFF_FFFF;

  // descriptor offsets, byte addresses of aligned words
  localparam logic [7:0] OFS_FLAGS     = 8'h00;
  localparam logic [7:0] OFS_DEFAULT   = 8'h04;
  localparam logic [7:0] OFS_SAVED     = 8'h08;
  localparam logic [7:0] OFS_CURRENT   = 8'h0C;
  localparam logic [7:0] OFS_RECOVERY  = 8'h10;
  localparam logic [7:0] OFS_MIN_LIMIT = 8'h14;
  localparam logic [7:0] OFS_MAX_LIMIT = 8'h18;
  // control, request and status registers
  localparam logic [7:0] OFS_CTRL      = 8'h20;
  localparam logic [7:0] OFS_SET_TIMER = 8'h24;
  localparam logic [7:0] OFS_SAVE_TIMER = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h2C;

  // flags byte sits in byte lane 1 of word 0
  localparam int unsigned FLAGS_LSB    = 8;
  localparam int unsigned FLG_SUPPORTED = 7;
  localparam int unsigned FLG_SAVABLE   = 6;
  localparam int unsigned FLG_CHANGEABLE = 5;
  localparam int unsigned FLG_DEF_EN    = 4;
  localparam int unsigned FLG_SAVED_EN  = 3;
  localparam int unsigned FLG_CUR_EN    = 2;

  // control register fields
  localparam int unsigned CTRL_FEAT_EN = 0;
  localparam int unsigned CTRL_CUR_EN  = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;

  // status register fields
  localparam int unsigned STAT_REFUSED = 0;
  localparam int unsigned STAT_IN_PC   = 1;
  localparam int unsigned STAT_RUNNING = 2;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : pct_pkg

// ---- pct_tick_div.sv ----
// divider that gives one enable pulse per timer unit
// assumes restart comes from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module pct_tick_div #(
  parameter int unsigned CYCLES = 1_000_000
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_restart,
  // enable pulse
  output logic      o_tick
);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("pct_tick_div: CYCLES must be at least one");
  end

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  // restart begins a fresh unit so a countdown never runs short
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (i_restart) begin
      next_cnt = 32'h0000_0000;
    end else if (cnt == 32'(CYCLES - 1)) begin
      next_cnt  = 32'h0000_0000;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt    <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
    end
  end

endmodule : pct_tick_div
`default_nettype wire

// ---- pct_timer.sv ----
// one power condition descriptor with its idle countdown, behind AXI4-Lite
// assumes i_cmd_done is a one-cycle pulse from logic on i_clk
//
// Summary of operation
// RULE1: supported flag at bit 7; other flags and timers depend on it.
// RULE2: bit 6 reports timer savable while the feature is enabled.
// RULE3: bit 5 reports timer changeable while the feature is enabled.
// RULE4: bit 4 default-timer-enabled valid whenever supported, feature on or off.
// RULE5: bit 3 saved-timer-enabled valid whenever supported, feature on or off.
// RULE6: bit 2 current-timer-enabled forced to zero when feature disabled.
// RULE7: timer runs only with feature on, current value nonzero, bit 2 set.
// RULE8: default timer is a fixed 32-bit value in 100 ms units.
// RULE9: all-ones timer value means at least the saturated maximum duration.
// RULE10: host stores saved timer by subcommand; device reports it back.
// RULE11: saved timer of zero disables this condition when feature enabled.
// RULE12: wait at least current value times 100 ms after command completion.
// RULE13: current value reads zero when feature off, unsupported, or bit 2 clear.
// RULE14: report nominal recovery time to active state, zero means unspecified.
// RULE15: recovery time survives every kind of reset.
// RULE16: minimum limit bounds programmed values; zero means no minimum.
// RULE17: maximum limit bounds programmed values; zero means no maximum.
// RULE18: minimum and maximum limits survive all resets.
// RULE19: reserved flag bits and reserved bytes read as zero.
// RULE20: countdown restarts at each completion; enter only on expiry.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module pct_timer
  import pct_pkg::*;
#(
  parameter bit          SUPPORTED     = 1'b1,
  parameter bit          SAVABLE       = 1'b1,
  parameter bit          CHANGEABLE    = 1'b1,
  parameter logic [31:0] DEFAULT_TIMER = 32'h0000_0064,
  parameter logic [31:0] RECOVERY_TIME = 32'h0000_0000,
  parameter logic [31:0] MIN_LIMIT     = 32'h0000_0000,
  parameter logic [31:0] MAX_LIMIT     = 32'h0000_0000,
  parameter int unsigned UNIT_CYCLES   = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // axi4-lite write address
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // axi4-lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // axi4-lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read address
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // axi4-lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // command engine
  input  wire logic        i_cmd_done,
  // power condition state
  output logic             o_in_power_condition,
  output logic             o_timer_running
);

  if (UNIT_CYCLES < 1 ||
      (MIN_LIMIT != 32'h0000_0000 && MAX_LIMIT != 32'h0000_0000 && MIN_LIMIT > MAX_LIMIT)) begin : g_bad_params
    $error("pct_timer: UNIT_CYCLES below one or MIN_LIMIT above MAX_LIMIT");
  end

  typedef enum logic [1:0] {PCT_OFF, PCT_COUNT, PCT_ENTERED} pct_state_e;

  // bus state
  logic        aw_hold, next_aw_hold;
  logic [7:0]  aw_addr, next_aw_addr;
  logic        w_hold, next_w_hold;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // descriptor state
  logic [1:0]  ctrl, next_ctrl;
  logic [31:0] saved, next_saved;
  logic [31:0] cur_q, next_cur_q;
  logic        refused, next_refused;
  logic        gate_q, next_gate_q;
  // countdown state
  pct_state_e  state, next_state;
  logic [31:0] remain, next_remain;
  logic        tick;
  logic        restart;

  // derived flags
  logic        feat_en;
  logic        cur_gate;
  logic [31:0] cur_vis;
  logic [7:0]  flags;
  logic        do_write;
  logic [31:0] wmerged;

  assign feat_en  = SUPPORTED && ctrl[CTRL_FEAT_EN];
  assign cur_gate = feat_en && ctrl[CTRL_CUR_EN];                        // RULE6
  assign cur_vis  = cur_gate ? cur_q : 32'h0000_0000;                    // RULE13

  // flags byte; everything below the supported bit is masked when unsupported
  always_comb begin
    flags                 = 8'h00;                                       // RULE19
    flags[FLG_SUPPORTED]  = SUPPORTED;                                   // RULE1
    flags[FLG_SAVABLE]    = SUPPORTED && SAVABLE;                        // RULE2
    flags[FLG_CHANGEABLE] = SUPPORTED && CHANGEABLE;                     // RULE3
    flags[FLG_DEF_EN]     = SUPPORTED && (DEFAULT_TIMER != 32'h0000_0000); // RULE4
    flags[FLG_SAVED_EN]   = SUPPORTED && (saved != 32'h0000_0000);       // RULE5
    flags[FLG_CUR_EN]     = cur_gate;                                    // RULE6
  end

  // legal inside whichever limits are given; zero always, so the host can disable
  function automatic logic in_limits(input logic [31:0] v);
    logic lo_ok;
    logic hi_ok;
    lo_ok = (MIN_LIMIT == 32'h0000_0000) || (v >= MIN_LIMIT);            // RULE16
    hi_ok = (MAX_LIMIT == 32'h0000_0000) || (v <= MAX_LIMIT);            // RULE17
    return (v == 32'h0000_0000) || (lo_ok && hi_ok);                     // RULE11
  endfunction : in_limits

  // byte-enable merge against zero; request registers take the whole word
  always_comb begin
    wmerged = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) wmerged[b*8 +: 8] = w_data[b*8 +: 8];
    end
  end

  assign do_write  = aw_hold && w_hold && !bvalid;
  assign o_awready = !aw_hold && !bvalid;
  assign o_wready  = !w_hold && !bvalid;
  assign o_arready = !rvalid;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_rvalid  = rvalid;
  assign o_rresp   = rresp;
  assign o_rdata   = rdata;

  // write channel: address and data are taken in either order, answered together
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ctrl    = ctrl;
    next_saved   = saved;
    next_cur_q   = cur_q;
    next_refused = refused;
    next_gate_q  = cur_gate;
    if (i_awvalid && o_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_hold = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    // enabling the timer starts from the saved value; saved zero keeps it off
    if (cur_gate && !gate_q) begin
      next_cur_q = saved;                                                // RULE11
    end
    if (!cur_gate) begin
      next_cur_q = 32'h0000_0000;                                        // RULE13
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_addr)
        OFS_CTRL: begin
          if (w_strb[0]) next_ctrl = wmerged[1:0];
        end
        OFS_SET_TIMER: begin
          // changes the current value only; refused when not changeable
          if (CHANGEABLE && feat_en && in_limits(w_data)) begin          // RULE3
            next_refused = 1'b0;
            if (cur_gate) next_cur_q = w_data;
          end else begin
            next_refused = 1'b1;
            next_bresp   = RESP_SLVERR;
          end
        end
        OFS_SAVE_TIMER: begin
          // stores the value for later enables and applies it now when bit 2 is set
          if (SAVABLE && CHANGEABLE && feat_en && in_limits(w_data)) begin // RULE2
            next_refused = 1'b0;
            next_saved   = w_data;                                       // RULE10
            if (cur_gate) next_cur_q = w_data;
          end else begin
            next_refused = 1'b1;
            next_bresp   = RESP_SLVERR;
          end
        end
        OFS_FLAGS, OFS_DEFAULT, OFS_SAVED, OFS_CURRENT,
        OFS_RECOVERY, OFS_MIN_LIMIT, OFS_MAX_LIMIT, OFS_STATUS: begin
          next_bresp = RESP_SLVERR;                                      // read-only words
        end
        default: begin
          next_bresp = RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      ctrl    <= CTRL_RESET;
      saved   <= DEFAULT_TIMER;
      cur_q   <= 32'h0000_0000;
      refused <= 1'b0;
      gate_q  <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      ctrl    <= next_ctrl;
      saved   <= next_saved;
      cur_q   <= next_cur_q;
      refused <= next_refused;
      gate_q  <= next_gate_q;
    end
  end

  // read channel: one cycle from address to data
  always_comb begin
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;                                       // RULE19
      unique case (i_araddr)
        OFS_FLAGS:      next_rdata[FLAGS_LSB +: 8] = flags;
        OFS_DEFAULT:    next_rdata = SUPPORTED ? DEFAULT_TIMER : 32'h0000_0000; // RULE8
        OFS_SAVED:      next_rdata = SUPPORTED ? saved : 32'h0000_0000;  // RULE10
        OFS_CURRENT:    next_rdata = cur_vis;                            // RULE13
        OFS_RECOVERY:   next_rdata = RECOVERY_TIME;                      // RULE14
        OFS_MIN_LIMIT:  next_rdata = MIN_LIMIT;                          // RULE16
        OFS_MAX_LIMIT:  next_rdata = MAX_LIMIT;                          // RULE17
        OFS_CTRL:       next_rdata[1:0] = ctrl;
        OFS_SET_TIMER:  next_rdata = cur_vis;
        OFS_SAVE_TIMER: next_rdata = SUPPORTED ? saved : 32'h0000_0000;
        OFS_STATUS: begin
          next_rdata[STAT_REFUSED] = refused;
          next_rdata[STAT_IN_PC]   = (state == PCT_ENTERED);
          next_rdata[STAT_RUNNING] = (state == PCT_COUNT);
        end
        default: begin
          next_rresp = RESP_DECERR;
        end
      endcase
    end
  end

  // limits and recovery are parameters, so no reset can disturb them
  always_ff @(posedge i_clk or posedge i_rst) begin                      // RULE15 RULE18
    if (i_rst) begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end else begin
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // unit divider restarts with the countdown so the first unit is a full one
  assign restart = i_cmd_done || (state == PCT_OFF);

  pct_tick_div #(
    .CYCLES (UNIT_CYCLES)
  ) u_unit (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_restart (restart),
    .o_tick    (tick)
  );

  // countdown: reloaded at each completion, entered only when it runs out
  always_comb begin
    next_state  = state;
    next_remain = remain;
    if (!cur_gate || cur_vis == 32'h0000_0000) begin                     // RULE7
      next_state  = PCT_OFF;
      next_remain = 32'h0000_0000;
    end else if (i_cmd_done) begin
      next_state  = PCT_COUNT;                                           // RULE20
      next_remain = cur_vis;                                             // RULE12
    end else begin
      unique case (state)
        PCT_OFF: begin
          // enabled with no completion seen yet; count from now
          next_state  = PCT_COUNT;
          next_remain = cur_vis;
        end
        PCT_COUNT: begin
          // all-ones means at least the maximum, so it never expires
          if (tick && remain != TIMER_SATURATED) begin                   // RULE9
            next_remain = remain - 32'h0000_0001;
            if (remain == 32'h0000_0001) next_state = PCT_ENTERED;       // RULE12
          end
        end
        PCT_ENTERED: begin
          next_remain = 32'h0000_0000;
        end
        default: begin
          next_state = PCT_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state  <= PCT_OFF;
      remain <= 32'h0000_0000;
    end else begin
      state  <= next_state;
      remain <= next_remain;
    end
  end

  assign o_in_power_condition = (state == PCT_ENTERED);                  // RULE20
  assign o_timer_running      = (state == PCT_COUNT);                    // RULE7

endmodule : pct_timer
`default_nettype wire

// ---- pct_timer_assertions.sv ----
// checker for pct_timer: bus handshakes and countdown timing at the top ports
// assumes one clock i_clk and an asynchronous active-high i_rst
`timescale 1ns/100ps
`default_nettype none
module pct_timer_chk #(
  parameter int unsigned UNIT_CYCLES = 4
) (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // write side
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  // read side
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  // countdown
  input wire logic        i_cmd_done,
  input wire logic        o_in_power_condition,
  input wire logic        o_timer_running
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // a completion that lands while the countdown is live or has expired
  sequence s_cmd_live;
    i_cmd_done && (o_timer_running || o_in_power_condition);
  endsequence
  // the moment the condition is entered
  sequence s_entry;
    $rose(o_in_power_condition);
  endsequence

  // bus handshakes: write answers only after acceptance, read data held until taken
  chk_b_after_take: assert property ($rose(o_bvalid) |-> !$past(o_awready) && !$past(o_wready))
    else $error("write response without both halves taken");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data dropped or changed before taken");
  chk_ar_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late after address taken");
  chk_wr_block: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  chk_rd_block: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");

  // countdown: never both states, never early, restarted by completions
  chk_run_excl: assert property (!(o_timer_running && o_in_power_condition))
    else $error("running and entered at once");
  chk_min_wait: assert property (s_entry |-> $past(o_timer_running) && $past(o_timer_running, UNIT_CYCLES))
    else $error("condition entered before one full unit");
  chk_cmd_restart: assert property (s_cmd_live |=> o_timer_running && !o_in_power_condition)
    else $error("completion did not restart the countdown");
  chk_wake_cause: assert property ($fell(o_in_power_condition) && o_timer_running |-> $past(i_cmd_done))
    else $error("left the condition without a completion");
endmodule : pct_timer_chk

bind pct_timer pct_timer_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_pct_chk (
  .i_clk(i_clk), .i_rst(i_rst), .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .i_cmd_done(i_cmd_done),
  .o_in_power_condition(o_in_power_condition), .o_timer_running(o_timer_running));
`default_nettype wire

// ---- pct_cmd_model.sv ----
// completion source standing in for the host-side command engine
// assumes the bench pulses i_go for one cycle; i_busy sets how slow it answers
`timescale 1ns/100ps
`default_nettype none
module pct_cmd_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // request from the bench
  input  wire logic       i_go,
  input  wire logic [3:0] i_busy,
  // completion pulse toward the block
  output logic            o_cmd_done
);
  logic       active;
  logic       next_active;
  logic       next_done;
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // count the busy time down, then one single-cycle completion
  always_comb begin
    next_active = active;
    next_cnt    = cnt;
    next_done   = 1'b0;
    if (i_go) begin
      next_active = 1'b1;
      next_cnt    = i_busy;
    end else if (active && cnt == 4'h0) begin
      next_active = 1'b0;
      next_done   = 1'b1;
    end else if (active) begin
      next_cnt = cnt - 4'h1;
    end
  end

  // state registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      active     <= 1'b0;
      cnt        <= 4'h0;
      o_cmd_done <= 1'b0;
    end else begin
      active     <= next_active;
      cnt        <= next_cnt;
      o_cmd_done <= next_done;
    end
  end
endmodule : pct_cmd_model
`default_nettype wire

// ---- power_condition_timer_descriptor_test.sv ----
// self-checking bench for pct_timer, registers over AXI4-Lite, compared with a model
// assumes pct_pkg, pct_timer, pct_cmd_model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module power_condition_timer_descriptor_test import pct_pkg::*;;
  localparam logic [31:0] DEF_T = 32'h0000_0003, REC_T = 32'h0000_0007;
  localparam logic [31:0] MIN_T = 32'h0000_0002, MAX_T = 32'h0000_0014;
  localparam int UNIT = 4;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, cmd_done, in_pc, running;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, val;
  logic [1:0] bresp, rresp;
  logic [3:0] busy = 4'h0;
  int n_errors = 0, n_checks = 0, m_ctrl, m_saved, m_cur, m_ref, n;
  int seed = 32'h103C3A6B;
  logic [7:0] sweep_a [11] = '{OFS_FLAGS, OFS_DEFAULT, OFS_SAVED, OFS_CURRENT, OFS_RECOVERY,
    OFS_MIN_LIMIT, OFS_MAX_LIMIT, OFS_CTRL, OFS_SET_TIMER, OFS_SAVE_TIMER, 8'h30};

  always #50 clk = ~clk;

  pct_timer #(.DEFAULT_TIMER(DEF_T), .RECOVERY_TIME(REC_T), .MIN_LIMIT(MIN_T), .MAX_LIMIT(MAX_T),
    .UNIT_CYCLES(UNIT)) DUT (.i_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_cmd_done(cmd_done), .o_in_power_condition(in_pc), .o_timer_running(running));
  pct_cmd_model u_host (.i_clk(clk), .i_rst(rst), .i_go(go), .i_busy(busy), .o_cmd_done(cmd_done));

  // reference model of the descriptor; status bits 1 and 2 only read while idle
  function automatic logic [1:0] m_rresp(input logic [7:0] a);
    m_rresp = (a <= OFS_STATUS && a[1:0] == 2'b00 && a != 8'h1C) ? RESP_OKAY : RESP_DECERR;
  endfunction : m_rresp
  function automatic logic [31:0] m_read(input logic [7:0] a);
    logic g;
    g = (m_ctrl == 3);
    case (a)
      OFS_FLAGS:                  m_read = {16'h0000, 3'b111, DEF_T != 0, m_saved != 0, g, 10'h000};
      OFS_DEFAULT:                m_read = DEF_T;
      OFS_SAVED, OFS_SAVE_TIMER:  m_read = 32'(m_saved);
      OFS_CURRENT, OFS_SET_TIMER: m_read = g ? 32'(m_cur) : 32'h0;
      OFS_RECOVERY:               m_read = REC_T;
      OFS_MIN_LIMIT:              m_read = MIN_T;
      OFS_MAX_LIMIT:              m_read = MAX_T;
      OFS_CTRL:                   m_read = 32'(m_ctrl);
      OFS_STATUS:                 m_read = 32'(m_ref);
      default:                    m_read = 32'h0;
    endcase
  endfunction : m_read
  // requests need the feature on and a value of zero or inside the limits
  function automatic logic [1:0] m_write(input logic [7:0] a, input logic [31:0] d);
    logic ok;
    ok = m_ctrl[0] && (d == 0 || (d >= MIN_T && d <= MAX_T));
    if (a == OFS_CTRL) begin
      if (m_ctrl != 3 && d[1:0] == 2'h3) m_cur = m_saved;
      m_ctrl = d[1:0];
      m_write = RESP_OKAY;
    end else if (a == OFS_SET_TIMER || a == OFS_SAVE_TIMER) begin
      m_ref = !ok;
      m_write = ok ? RESP_OKAY : RESP_SLVERR;
      if (ok) m_cur = d;
      if (ok && a == OFS_SAVE_TIMER) m_saved = d;
    end else m_write = (m_rresp(a) == RESP_OKAY) ? RESP_SLVERR : RESP_DECERR;
  endfunction : m_write

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic fail(input string what);
    n_errors++;
    $display("unexpected at %0t: %s", $time, what);
  endtask : fail
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) fail($sformatf("%s got %h want %h", what, got, exp));
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    n_checks++;
    if (got !== exp) fail($sformatf("%s response %h want %h", what, got, exp));
  endtask : chk_resp
  task automatic chk_cycles(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) fail($sformatf("entry after %0d cycles, want %0d..%0d", got, lo, hi));
  endtask : chk_cycles
  // a wait that ran out ends the run
  task automatic guard(input int c, input int lim);
    if (c >= lim) begin
      fail("wait ran out");
      print_verdict();
    end
  endtask : guard

  // handshakes sampled at the falling edge, so the rising edge that follows takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) break;
    end
    bready <= 1'b0;
    guard(n, 40);
    chk_resp(r, m_write(a, d), "write");
  endtask : wr
  // rready is raised only once data shows, so the slave must hold it a cycle
  task automatic rd(input logic [7:0] a);
    logic ta, tk, rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tk = rvalid && rready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tk) break;
      if (rv) rready <= 1'b1;
    end
    rready <= 1'b0;
    guard(n, 40);
    chk_resp(r, m_rresp(a), "read");
    chk_word(d, m_read(a), $sformatf("read %h", a));
  endtask : rd
  task automatic sweep;
    foreach (sweep_a[i]) rd(sweep_a[i]);
  endtask : sweep
  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    m_ctrl = 0;
    m_saved = DEF_T;
    m_cur = 0;
    m_ref = 0;
  endtask : do_reset
  // one completion from the partner; returns at the edge that hands it over
  task automatic cmd(input logic [3:0] b);
    @(posedge clk);
    go <= 1'b1;
    busy <= b;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (cmd_done === 1'b1) break;
    end
    guard(n, 40);
    @(posedge clk);
  endtask : cmd
  task automatic measure(input int units);
    for (n = 1; n < 200; n++) begin
      @(negedge clk);
      if (in_pc === 1'b1) break;
    end
    guard(n, 200);
    chk_cycles(n, units * UNIT, units * UNIT + 3);
    @(posedge clk);
  endtask : measure

  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    do_reset();
    sweep();
    wr(OFS_DEFAULT, 32'h0000_0001);
    wr(8'h30, 32'h0000_0000);
    wr(OFS_SET_TIMER, 32'h0000_0005);
    rd(OFS_STATUS);
    wr(OFS_CTRL, 32'h0000_0003);
    sweep();
    wr(OFS_SAVE_TIMER, 32'h0000_0001);
    wr(OFS_SAVE_TIMER, 32'h0000_0015);
    wr(OFS_SET_TIMER, 32'hFFFF_FFFF);
    val = 32'h0000_0002 + 32'($unsigned($random(seed)) % 19);
    wr(OFS_SAVE_TIMER, val);
    wr(OFS_SET_TIMER, 32'h0000_0003);
    sweep();
    for (int i = 0; i < 2; i++) begin
      cmd(4'(i * 7));
      measure(3);
    end
    cmd(4'h0);
    repeat (4) @(posedge clk);
    cmd(4'h3);
    measure(3);
    wr(OFS_SAVE_TIMER, 32'h0000_0000);
    sweep();
    cmd(4'h0);
    @(negedge clk);
    chk_word({30'h0, running, in_pc}, 32'h0, "idle state");
    wr(OFS_SET_TIMER, 32'h0000_0003);
    do_reset();
    sweep();
    wr(OFS_CTRL, 32'h0000_0001);
    sweep();
    rd(OFS_STATUS);
    print_verdict();
  end
endmodule : power_condition_timer_descriptor_test
`default_nettype wire
